// ---- rtl/tbstc_defines.svh ----
// Offsets, field positions, reset values and limits of the bid and test block
`ifndef TBSTC_DEFINES_SVH
`define TBSTC_DEFINES_SVH

`define TBSTC_ADDR_W 12
`define TBSTC_OFF_TEST 12'h118
`define TBSTC_OFF_BID 12'h138
`define TBSTC_OFF_TXREQ 12'h140
`define TBSTC_OFF_EVST 12'h144
`define TBSTC_OFF_EVMASK 12'h148
`define TBSTC_OFF_LINE 12'h14C

`define TBSTC_ID_BID 6'h18
`define TBSTC_ID_TEST 6'h19

`define TBSTC_BIT_IGN_LINK 7
`define TBSTC_BIT_CODEC_LOOP 9
`define TBSTC_BIT_ATT_LOOP 10
`define TBSTC_BIT_NO_BACKOFF 11
`define TBSTC_BIT_FULL_DUPLEX 14
`define TBSTC_BIT_REJECTED 7
`define TBSTC_BIT_SPACE_NOW 8
`define TBSTC_BIT_LINK_GOOD 7
`define TBSTC_BIT_SUPPRESS 16

`define TBSTC_EV_REJECTED 0
`define TBSTC_EV_LAUNCHED 1
`define TBSTC_EV_LINK_LOST 2
`define TBSTC_EV_N 3

`define TBSTC_TEST_RESET 16'h0000
`define TBSTC_TXREQ_RESET 17'h00000
`define TBSTC_EVMASK_RESET 3'h0

`define TBSTC_LEN_MAX_FCS 16'h05EA
`define TBSTC_LEN_MAX_RAW 16'h05EE
`define TBSTC_LEN_MIN 16'h0004

`endif

// ---- rtl/tbstc_pkg.sv ----
// Types shared by the bid and test control block
package tbstc_pkg;
  typedef logic [15:0] tbstc_len_t;
  typedef logic [31:0] tbstc_word_t;
  typedef logic [11:0] tbstc_addr_t;
  // Gray order along idle, check, issue
  typedef enum logic [1:0] {
    BID_IDLE = 2'b00,
    BID_CHECK = 2'b01,
    BID_ISSUE = 2'b11
  } tbstc_bid_e;
endpackage : tbstc_pkg

// ---- rtl/tbstc_flag.sv ----
// Sticky flags, set by hardware and cleared by a mask, set wins
`timescale 1ns/100ps
module tbstc_flag #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] q_next;

  assign q_next = set | (q & ~clr);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= q_next;
    end
  end
endmodule : tbstc_flag

// ---- rtl/tbstc_bid_chk.sv ----
// Registered length verdict for one transmit request
`timescale 1ns/100ps
`include "tbstc_defines.svh"
module tbstc_bid_chk
  import tbstc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire tbstc_pkg::tbstc_len_t len,
  input wire logic suppress_fcs_append,
  output logic done,
  output logic too_long,
  output logic too_short
);
  import tbstc_pkg::*;

  logic long_fcs;
  logic long_raw;
  logic short_len;

  assign long_fcs = (len > `TBSTC_LEN_MAX_FCS) && !suppress_fcs_append;
  assign long_raw = len > `TBSTC_LEN_MAX_RAW;
  assign short_len = len < `TBSTC_LEN_MIN;

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      too_long <= 1'b0;
      too_short <= 1'b0;
    end else begin
      done <= start;
      if (start) begin
        too_long <= long_fcs | long_raw;
        too_short <= short_len;
      end
    end
  end
endmodule : tbstc_bid_chk

// ---- rtl/tbstc_top.sv ----
// Transmit bid status and diagnostic test control with APB register access
//
// Operation
// - Bid status reads identifier 011000 in bits 5:0
// - Reject over 1514 bytes when FCS appended
// - Reject over 1518 bytes in every case
// - Short frames refused without rejected flag
// - Space-now bit mirrors buffer ready input
// - Space-now bit never raises an interrupt
// - Ignore bit opens traffic on bad link
// - Bad link, bit clear: block, keep pulses unless in codec loopback
// - Bad link, bit set: no link pulses
// - Suppress option sends frame without FCS
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "tbstc_defines.svh"
module tbstc_top
  import tbstc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire tbstc_pkg::tbstc_addr_t PADDR,
  input wire tbstc_pkg::tbstc_word_t PWDATA,
  output tbstc_pkg::tbstc_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BUF_TX_READY,
  input wire logic LINK_GOOD,
  output logic TX_START,
  output tbstc_pkg::tbstc_len_t TX_LEN,
  output logic TX_APPEND_FCS,
  output logic TRAFFIC_EN,
  output logic LINK_PULSE_EN,
  output logic LOOP_INTERNAL,
  output logic LOOP_ATTACH,
  output logic TP_TX_EN,
  output logic AUI_TX_EN,
  output logic NO_BACKOFF,
  output logic FULL_DUPLEX,
  output logic IRQ
);
  import tbstc_pkg::*;

  // Register state
  logic [15:0] test_reg;
  logic [15:0] test_next;
  logic [16:0] txreq_reg;
  logic [16:0] txreq_next;
  logic [`TBSTC_EV_N-1:0] evmask_reg;
  logic [`TBSTC_EV_N-1:0] evmask_next;
  logic space_reg;
  logic link_reg;
  tbstc_bid_e bid_reg;
  tbstc_bid_e bid_next;

  // Bus decode
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic hit_test;
  logic hit_bid;
  logic hit_txreq;
  logic hit_evst;
  logic hit_evmask;
  logic hit_line;
  logic hit_any;
  logic hit_ro;
  logic bad_access;
  tbstc_word_t rd_word;
  tbstc_word_t test_word;
  tbstc_word_t bid_word;
  tbstc_word_t line_word;

  // Bid path
  logic bid_start;
  logic chk_done;
  logic chk_long;
  logic chk_short;
  logic bid_reject;
  logic bid_accept;
  logic rejected_flag;
  logic [`TBSTC_EV_N-1:0] ev_set;
  logic [`TBSTC_EV_N-1:0] ev_clr;
  logic [`TBSTC_EV_N-1:0] ev_flags;
  logic link_lost;

  // Test setup fields
  logic ignore_link_integrity;
  logic codec_internal_loopback;
  logic attachment_port_loopback;
  logic no_collision_backoff;
  logic full_duplex_select;
  logic traffic_ok;
  logic pulses_on;
  logic ext_tx_on;

  // Access phase takes two cycles: PREADY rises on the second
  assign access = PSEL & PENABLE;
  assign wr_fire = access & PREADY & PWRITE;
  assign rd_fire = access & ~PREADY & ~PWRITE;

  assign hit_test = PADDR == `TBSTC_OFF_TEST;
  assign hit_bid = PADDR == `TBSTC_OFF_BID;
  assign hit_txreq = PADDR == `TBSTC_OFF_TXREQ;
  assign hit_evst = PADDR == `TBSTC_OFF_EVST;
  assign hit_evmask = PADDR == `TBSTC_OFF_EVMASK;
  assign hit_line = PADDR == `TBSTC_OFF_LINE;
  assign hit_any = hit_test | hit_bid | hit_txreq | hit_evst | hit_evmask | hit_line;
  assign hit_ro = hit_bid | hit_line;
  assign bad_access = ~hit_any | (PWRITE & hit_ro);

  // Test setup keeps only its control bits; the identifier is not stored
  assign ignore_link_integrity = test_reg[`TBSTC_BIT_IGN_LINK];
  assign codec_internal_loopback = test_reg[`TBSTC_BIT_CODEC_LOOP];
  assign attachment_port_loopback = test_reg[`TBSTC_BIT_ATT_LOOP];
  assign no_collision_backoff = test_reg[`TBSTC_BIT_NO_BACKOFF];
  assign full_duplex_select = test_reg[`TBSTC_BIT_FULL_DUPLEX];

  assign test_word = {16'h0000, test_reg[15:6], `TBSTC_ID_TEST};
  assign bid_word = {23'h000000, space_reg, rejected_flag, 1'b0, `TBSTC_ID_BID};
  assign line_word = {24'h000000, link_reg, 7'h00};

  assign rd_word = hit_test ? test_word :
                   hit_bid ? bid_word :
                   hit_txreq ? {15'h0000, txreq_reg} :
                   hit_evst ? {{(32 - `TBSTC_EV_N){1'b0}}, ev_flags} :
                   hit_evmask ? {{(32 - `TBSTC_EV_N){1'b0}}, evmask_reg} :
                   hit_line ? line_word : 32'h00000000;

  // Only control bits are writable in the test setup
  assign test_next = (wr_fire & hit_test) ?
                     {1'b0, PWDATA[`TBSTC_BIT_FULL_DUPLEX], 2'b00, PWDATA[11:9], 1'b0,
                      PWDATA[`TBSTC_BIT_IGN_LINK], 7'h00} : test_reg;
  assign txreq_next = (wr_fire & hit_txreq) ? PWDATA[16:0] : txreq_reg;
  assign evmask_next = (wr_fire & hit_evmask) ? PWDATA[`TBSTC_EV_N-1:0] : evmask_reg;
  assign ev_clr = (wr_fire & hit_evst) ? PWDATA[`TBSTC_EV_N-1:0] : '0;

  // A request write while a bid is in flight still loads the request register but starts no bid
  assign bid_start = wr_fire & hit_txreq & (bid_reg == BID_IDLE);

  always_comb begin
    bid_next = bid_reg;
    unique case (bid_reg)
      BID_IDLE: begin
        if (bid_start) begin
          bid_next = BID_CHECK;
        end
      end
      BID_CHECK: begin
        if (chk_done) begin
          bid_next = BID_ISSUE;
        end
      end
      BID_ISSUE: begin
        bid_next = BID_IDLE;
      end
      default: begin
        bid_next = BID_IDLE;
      end
    endcase
  end

  tbstc_bid_chk u_chk (
    .clk(CORE_CLK),
    .rst(RST),
    .start(bid_start),
    .len(PWDATA[15:0]),
    .suppress_fcs_append(PWDATA[`TBSTC_BIT_SUPPRESS]),
    .done(chk_done),
    .too_long(chk_long),
    .too_short(chk_short)
  );

  assign bid_reject = chk_done & chk_long;
  assign bid_accept = chk_done & ~chk_long & ~chk_short;

  // Rejected flag describes the latest bid that is not too short: a good bid clears it
  tbstc_flag #(
    .W(1)
  ) u_rej (
    .clk(CORE_CLK),
    .rst(RST),
    .set(bid_reject),
    .clr(bid_accept),
    .q(rejected_flag)
  );

  // Space-now is not among the interrupt events
  assign link_lost = link_reg & ~LINK_GOOD;
  assign ev_set = {link_lost, bid_accept, bid_reject};

  tbstc_flag #(
    .W(`TBSTC_EV_N)
  ) u_ev (
    .clk(CORE_CLK),
    .rst(RST),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_flags)
  );

  assign traffic_ok = LINK_GOOD | ignore_link_integrity;
  assign pulses_on = LINK_GOOD | ~ignore_link_integrity;
  assign ext_tx_on = traffic_ok & ~codec_internal_loopback;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      test_reg <= `TBSTC_TEST_RESET;
    end else begin
      test_reg <= test_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      txreq_reg <= `TBSTC_TXREQ_RESET;
    end else begin
      txreq_reg <= txreq_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      evmask_reg <= `TBSTC_EVMASK_RESET;
    end else begin
      evmask_reg <= evmask_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bid_reg <= BID_IDLE;
    end else begin
      bid_reg <= bid_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      space_reg <= 1'b0;
      link_reg <= 1'b0;
    end else begin
      space_reg <= BUF_TX_READY;
      link_reg <= LINK_GOOD;
    end
  end

  // APB answer, registered
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & bad_access;
      if (rd_fire) begin
        PRDATA <= rd_word;
      end
    end
  end

  // Launch toward the transmitter
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TX_START <= 1'b0;
      TX_LEN <= 16'h0000;
      TX_APPEND_FCS <= 1'b1;
    end else begin
      TX_START <= bid_accept;
      if (bid_accept) begin
        TX_LEN <= txreq_reg[15:0];
        TX_APPEND_FCS <= ~txreq_reg[`TBSTC_BIT_SUPPRESS];
      end
    end
  end

  // Line and diagnostic controls
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TRAFFIC_EN <= 1'b0;
    end else begin
      TRAFFIC_EN <= traffic_ok;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LINK_PULSE_EN <= 1'b1;
    end else begin
      LINK_PULSE_EN <= pulses_on & ~codec_internal_loopback;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LOOP_INTERNAL <= 1'b0;
    end else begin
      LOOP_INTERNAL <= codec_internal_loopback;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LOOP_ATTACH <= 1'b0;
    end else begin
      LOOP_ATTACH <= attachment_port_loopback;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TP_TX_EN <= 1'b0;
    end else begin
      TP_TX_EN <= ext_tx_on;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      AUI_TX_EN <= 1'b0;
    end else begin
      AUI_TX_EN <= ~codec_internal_loopback;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      NO_BACKOFF <= 1'b0;
    end else begin
      NO_BACKOFF <= no_collision_backoff;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      FULL_DUPLEX <= 1'b0;
    end else begin
      FULL_DUPLEX <= full_duplex_select;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(ev_flags & evmask_reg);
    end
  end
endmodule : tbstc_top

// ---- bench/tbstc_top_asserts.sv ----
// Port-level checks of the bid and test block
`timescale 1ns/100ps
module tbstc_chk
  import tbstc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire tbstc_pkg::tbstc_addr_t PADDR,
  input wire tbstc_pkg::tbstc_word_t PWDATA,
  input wire tbstc_pkg::tbstc_word_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic LINK_GOOD,
  input wire logic TX_START,
  input wire tbstc_pkg::tbstc_len_t TX_LEN,
  input wire logic TX_APPEND_FCS,
  input wire logic TRAFFIC_EN,
  input wire logic LINK_PULSE_EN,
  input wire logic LOOP_INTERNAL,
  input wire logic TP_TX_EN,
  input wire logic AUI_TX_EN
);
  import tbstc_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire rd = PREADY && PSEL && !PWRITE;
  wire wr140 = PREADY && PSEL && PWRITE && PADDR == 12'h140;
  wire [15:0] ln = PWDATA[15:0];
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence access_s; PSEL && PENABLE && !PREADY ##1 PREADY; endsequence
  apb_wait_a: assert property (setup_s |=> access_s) else $error("ready timing");
  bid_id_a: assert property (rd && PADDR == 12'h138 |-> PRDATA[5:0] == 6'h18)
    else $error("bid id");
  test_id_a: assert property (rd && PADDR == 12'h118 |-> PRDATA[5:0] == 6'h19)
    else $error("test id");
  ro_err_a: assert property (PREADY && PSEL && PWRITE && PADDR == 12'h138 |-> PSLVERR)
    else $error("ro write");
  long_rej_a: assert property (wr140 && (ln > 16'h05EE
    || ln > 16'h05EA && !PWDATA[16] || ln < 16'h0004) |=> !TX_START [*3])
    else $error("bad launch");
  launch_a: assert property (wr140 && ln >= 16'h0004
    && (ln <= 16'h05EA || PWDATA[16] && ln <= 16'h05EE)
    |-> ##2 TX_START && TX_LEN == $past(ln, 2) && TX_APPEND_FCS == !$past(PWDATA[16], 2))
    else $error("no launch");
  traffic_a: assert property (!$past(RST) && $past(LINK_GOOD) |-> TRAFFIC_EN)
    else $error("traffic");
  pulse_a: assert property (!$past(RST) && !$past(LINK_GOOD) && !LOOP_INTERNAL
    |-> LINK_PULSE_EN != TRAFFIC_EN) else $error("pulses");
  block_a: assert property (!TRAFFIC_EN |-> !TP_TX_EN) else $error("blocked");
  loop_a: assert property (LOOP_INTERNAL |-> !TP_TX_EN && !AUI_TX_EN)
    else $error("loop");
endmodule : tbstc_chk

bind tbstc_top tbstc_chk u_asserts (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_GOOD(LINK_GOOD), .TX_START(TX_START),
  .TX_LEN(TX_LEN), .TX_APPEND_FCS(TX_APPEND_FCS), .TRAFFIC_EN(TRAFFIC_EN),
  .LINK_PULSE_EN(LINK_PULSE_EN), .LOOP_INTERNAL(LOOP_INTERNAL), .TP_TX_EN(TP_TX_EN),
  .AUI_TX_EN(AUI_TX_EN));

// ---- bench/tbstc_medium.sv ----
// Medium and buffer side model: link state, ready level, launch count
`timescale 1ns/100ps
module tbstc_medium (
  input wire logic clk,
  input wire logic link_cmd,
  input wire logic ready_cmd,
  input wire logic tx_start,
  output logic link_good,
  output logic buf_ready,
  output int launches
);
  initial begin
    launches = 0;
    link_good = 1'b1;
    buf_ready = 1'b0;
  end
  always @(posedge clk) begin
    link_good <= link_cmd;
    buf_ready <= ready_cmd;
    if (tx_start === 1'b1) launches <= launches + 1;
  end
endmodule : tbstc_medium

// ---- bench/tbstc_top_tb.sv ----
// Self-checking bench of the bid and test block
`timescale 1ns/100ps
module tbstc_top_tb;
  import tbstc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, link_cmd = 1, ready_cmd = 0;
  logic pready, pslverr, buf_rdy, link_good, tx_start, fcs, traffic, pulse, err;
  logic lp_int, lp_att, tp_en, aui_en, no_bo, fdup, irq;
  tbstc_addr_t paddr = '0;
  tbstc_word_t pwdata = '0, prdata, rdat;
  tbstc_len_t tx_len;
  int launches, fail_count = 0, checked = 0;
  always #50 clk = ~clk;
  tbstc_top DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUF_TX_READY(buf_rdy), .LINK_GOOD(link_good), .TX_START(tx_start), .TX_LEN(tx_len),
    .TX_APPEND_FCS(fcs), .TRAFFIC_EN(traffic), .LINK_PULSE_EN(pulse),
    .LOOP_INTERNAL(lp_int), .LOOP_ATTACH(lp_att), .TP_TX_EN(tp_en), .AUI_TX_EN(aui_en),
    .NO_BACKOFF(no_bo), .FULL_DUPLEX(fdup), .IRQ(irq));
  tbstc_medium u_med (.clk(clk), .link_cmd(link_cmd), .ready_cmd(ready_cmd),
    .tx_start(tx_start), .link_good(link_good), .buf_ready(buf_rdy), .launches(launches));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input tbstc_addr_t a, input logic w, input tbstc_word_t d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task t_regs;
    apb(12'h118, 0, 0);
    chk("test reset", 32'h19, rdat);
    apb(12'h138, 1, 32'hFFFF_FFFF);
    chk("ro error", 1, err);
    apb(12'h138, 0, 0);
    chk("bid id", 6'h18, rdat[5:0]);
    chk("read error", 0, err);
    apb(12'h100, 0, 0);
    chk("unmapped", 1, err);
    apb(12'h148, 0, 0);
    chk("mask reset", 0, rdat);
    apb(12'h118, 1, 32'hFFFF_FFFF);
    apb(12'h118, 0, 0);
    chk("test bits", 32'h4E99, rdat);
    chk("loop outs", 6'h3C, {lp_int, lp_att, no_bo, fdup, tp_en, aui_en});
    apb(12'h118, 1, 0);
  endtask : t_regs
  task t_link;
    link_cmd <= 0;
    repeat (3) @(posedge clk);
    chk("bad link", 2'b01, {traffic, pulse});
    apb(12'h14C, 0, 0);
    chk("line state", 0, rdat[7]);
    apb(12'h118, 1, 32'h80);
    repeat (2) @(posedge clk);
    chk("ignore", 2'b10, {traffic, pulse});
    link_cmd <= 1;
    apb(12'h118, 1, 0);
    repeat (2) @(posedge clk);
    chk("good link", 2'b11, {traffic, pulse});
  endtask : t_link
  task t_bid;
    int l [8];
    logic [7:0] s;
    logic go, rj, flag;
    int c;
    l = '{100, 3, 1514, 1515, 1515, 1518, 1519, 4};
    s = 8'h70;
    flag = 0;
    for (int i = 0; i < 8; i++) begin
      go = l[i] >= 4 && (l[i] <= 1514 || s[i] && l[i] <= 1518);
      rj = l[i] > 1518 || l[i] > 1514 && !s[i];
      flag = rj ? 1'b1 : go ? 1'b0 : flag;
      c = launches;
      apb(12'h140, 1, {15'h0, s[i], l[i][15:0]});
      repeat (4) @(posedge clk);
      chk("launch", go, launches - c);
      apb(12'h138, 0, 0);
      chk("rejected", flag, rdat[7]);
      if (go) chk("fcs", !s[i], fcs);
      if (go) chk("length", l[i], tx_len);
    end
  endtask : t_bid
  task t_irq;
    apb(12'h144, 0, 0);
    chk("events", 32'h7, rdat);
    chk("mask off", 0, irq);
    apb(12'h144, 1, 32'h7);
    apb(12'h148, 1, 32'h7);
    ready_cmd <= 1;
    repeat (4) @(posedge clk);
    chk("no irq", 0, irq);
    apb(12'h138, 0, 0);
    chk("space now", 1, rdat[8]);
    apb(12'h140, 1, 32'h700);
    repeat (4) @(posedge clk);
    chk("irq", 1, irq);
    apb(12'h148, 1, 32'h2);
    repeat (2) @(posedge clk);
    chk("masked", 0, irq);
    apb(12'h144, 0, 0);
    chk("status", 1, rdat[0]);
    apb(12'h144, 1, 32'h1);
    apb(12'h148, 1, 32'h1);
    repeat (2) @(posedge clk);
    chk("cleared", 0, irq);
  endtask : t_irq
  task give_verdict;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_link;
    t_bid;
    t_irq;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule : tbstc_top_tb
